// >>> rtl/prc_pkg.sv
// constants and types for the power, reset and charger control block
package prc_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] WDT_OFS    = 8'h08;
   localparam logic [7:0] GIO_OFS    = 8'h0C;

   // ****************************************
   // synchronised input positions
   // ****************************************
   localparam int IN_HS   = 0;
   localparam int IN_LS   = 1;
   localparam int IN_SUP  = 2;
   localparam int IN_BLOW = 3;
   localparam int IN_BFLT = 4;
   localparam int IN_TERM = 5;
   localparam int IN_RECH = 6;
   localparam int IN_LF   = 7;
   localparam int IN_RSTN = 8;
   localparam int IN_XTAL = 9;
   localparam int SYNC_W  = 10;
   localparam logic [SYNC_W-1:0] SYNC_RST = 10'h100; // pin idle high

   // ****************************************
   // field layouts and reset values
   // ****************************************
   localparam int GIO_N  = 12;
   localparam int WDT_W  = 24;
   localparam int WDT_LSB = 8;   // load field position in the word
   localparam int GVAL_LSB = 16; // pin value field position
   localparam int CTRL_W = 18;
   localparam logic [CTRL_W-1:0] CTRL_RST = 18'h0_3800; // slowest xtal
   localparam logic [3:0] CAUSE_POR = 4'h2;
   localparam logic [1:0] EN_PD_ON  = 2'h3;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_MHZ      = 200;
   localparam int LF_PERIOD_US = 1000;
   localparam int RST_MIN_US   = 1500;
   localparam int RST_LF_N =
      (RST_MIN_US + LF_PERIOD_US - 1) / LF_PERIOD_US + 1;
   localparam logic [1:0] RST_LF_EDGES = 2'(RST_LF_N);
   localparam int RST_HOLD_NS  = 80;
   localparam logic [4:0] RST_HOLD_CYC = 5'(RST_HOLD_NS * CLK_MHZ / 1000);
   localparam int LED_PERIOD_US = 1000;
   localparam int LED_ON_US     = 50;
   localparam int LED_CNT_W     = 18;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      CHG_OFF, CHG_TRICKLE, CHG_CC, CHG_CV, CHG_STANDBY
   } chg_state_type;

   typedef struct packed {
      logic [3:0] data_rate;
      logic [2:0] xtal_sel;
      logic [3:0] i_set;
      logic       led1_fw;
      logic       led0_fw;
      logic       fw_running;
      logic       deep_sleep;
      logic       fw_lvlr;
      logic       fw_hvlr;
      logic       fw_smps;
   } ctrl_type;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_type;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_type;

   typedef struct packed {
      logic smps_en;
      logic smps_pulse_skip;
      logic hvlr_en;
      logic hvlr_low_power;
      logic lvlr_en;
      logic lvlr_low_power;
   } reg_out_type;

   typedef struct packed {
      logic             uart_rx_pd;
      logic             uart_tx_pu;
      logic [3:0]       spi_pd;
      logic             rst_pu;
      logic             test_en_strong_pd;
      logic [GIO_N-1:0] gio_pd;
   } pulls_type;
endpackage

// >>> rtl/power_reset_charger_control.sv
// regulator enables, charger state machine, indicators and reset control
`timescale 1ns/100ps

// Summary of operation
// - switch-mode on by high pin, firmware, charger
// - high linear on by high pin, firmware, charger
// - low linear on by low pin, firmware, charger
// - deep sleep or reset forces low power
// - enable pins active high, weak pull-down
// - pin boots, firmware latch then holds on
// - high enable pin level readable by firmware
// - charger off when supply disconnected
// - below trickle threshold, trickle charge
// - above threshold, constant-current fast charge
// - at float voltage, constant-voltage charge
// - standby; recharge drop returns to fast
// - charging with supply lights indicator 0
// - indicator pulses until firmware runs
// - supply presence readable as status bit
// - two open-drain pads, pad 0 charger too
// - four reset sources combined
// - reset pin filtered on slow oscillator
// - reset makes pins inputs, outputs high-Z
// - reset assumes slowest crystal, free-run fallback
// - reset applies the listed pad pulls
// - warm reset keeps data rate and RAM
module power_reset_charger_control
   import prc_pkg::*;
#(
   parameter int LED_PERIOD_CYC = LED_PERIOD_US * CLK_MHZ,
   parameter int LED_ON_CYC     = LED_ON_US * CLK_MHZ
) (
   input  wire logic             pclk,            // 200 MHz clock
   input  wire logic             presetn,         // power-on reset
   input  wire apb_req_type      apb_req,         // apb request
   output apb_rsp_type           apb_rsp,         // apb answer
   input  wire logic             high_side_reg_enable_pin, // pin
   input  wire logic             low_side_reg_enable_pin,  // pin
   input  wire logic             charger_supply_input,     // present
   input  wire logic             battery_below_trickle,    // comparator
   input  wire logic             battery_at_float,         // comparator
   input  wire logic             charge_term_reached,      // comparator
   input  wire logic             battery_recharge_drop,    // comparator
   input  wire logic             lf_osc_clk,      // slow oscillator
   input  wire logic             reset_pin_n,     // reset pin
   input  wire logic             crystal_present, // crystal clock seen
   input  wire logic             uart_break_seen, // break pulse
   output reg_out_type           regs,            // regulator controls
   output pulls_type             pulls,           // pad pulls
   output logic [1:0]            en_pin_pulldown, // enable pin pulls
   output logic                  indicator_pad_0_oe_n, // sink when low
   output logic                  indicator_pad_1_oe_n, // sink when low
   output logic                  indicator_pad_0_out,  // always low
   output logic                  indicator_pad_1_out,  // always low
   output logic [GIO_N-1:0]      general_io_pins_oe_n, // drive low
   output logic [GIO_N-1:0]      general_io_pins_out,  // pin value
   output logic                  chg_trickle,     // trickle mode
   output logic                  chg_cc,          // constant current
   output logic                  chg_cv,          // constant voltage
   output logic [3:0]            chg_current,     // fast current step
   output logic [2:0]            xtal_sel,        // crystal setting
   output logic                  osc_freerun,     // no crystal
   output logic [3:0]            data_rate,       // kept over warm
   output logic                  ram_retained,    // last was warm
   output logic                  chip_reset       // internal reset
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [SYNC_W-1:0]    sync1;
      logic [SYNC_W-1:0]    sync2;
      logic                 lf_prev;
      logic [1:0]           rst_cnt;
      chg_state_type        chg;
      logic [LED_CNT_W-1:0] led_cnt;
      logic [WDT_W-1:0]     wdt_cnt;
      logic [WDT_W-1:0]     wdt_load;
      logic                 wdt_en;
      logic [4:0]           hold_cnt;
      logic                 in_rst;
      logic                 warm;
      logic [3:0]           cause;
      ctrl_type             ctrl;
      logic [GIO_N-1:0]     gio_dir;
      logic [GIO_N-1:0]     gio_val;
      apb_rsp_type          rsp;
      reg_out_type          regs;
      pulls_type            pulls;
      logic [1:0]           en_pd;
      logic                 led0_oe_n;
      logic                 led1_oe_n;
      logic [GIO_N-1:0]     gio_oe_n;
      logic [GIO_N-1:0]     gio_out;
      logic                 chg_tr;
      logic                 chg_cc;
      logic                 chg_cv;
      logic [3:0]           chg_cur;
      logic                 freerun;
   } state_type;

   state_type s_ff;
   state_type nxt_s;

   logic       lf_rise;
   logic       pin_trig;
   logic       wdt_exp;
   logic       trig;
   logic       chg_req;
   logic       led_pulse;
   logic       chg_lit;
   logic       lp;
   logic       acc;
   logic       done;
   logic [2:0] sel;
   logic [31:0] rd_word;

   // address decode: {mapped, word index}
   function automatic logic [2:0] decode(input logic [7:0] a);
      decode = {a[7:4] == 4'h0 && a[1:0] == 2'h0, a[3:2]};
   endfunction

   // charger delivering current
   function automatic logic charging(input chg_state_type c);
      charging = c == CHG_TRICKLE || c == CHG_CC || c == CHG_CV;
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      nxt_s = s_ff;
      // two-stage synchronisers for pins and comparators
      nxt_s.sync1 = {crystal_present, reset_pin_n, lf_osc_clk,
                     battery_recharge_drop, charge_term_reached,
                     battery_at_float, battery_below_trickle,
                     charger_supply_input, low_side_reg_enable_pin,
                     high_side_reg_enable_pin};
      nxt_s.sync2 = s_ff.sync1;
      nxt_s.lf_prev = s_ff.sync2[IN_LF];
      lf_rise = s_ff.sync2[IN_LF] & ~s_ff.lf_prev;

      // reset pin counted on slow oscillator edges
      if (s_ff.sync2[IN_RSTN]) begin
         nxt_s.rst_cnt = 2'h0;
      end else if (lf_rise && s_ff.rst_cnt != RST_LF_EDGES) begin
         nxt_s.rst_cnt = s_ff.rst_cnt + 2'h1;
      end
      pin_trig = s_ff.rst_cnt == RST_LF_EDGES;

      // watchdog countdown
      wdt_exp = s_ff.wdt_en && s_ff.wdt_cnt == 24'h00_0001;
      if (s_ff.wdt_en && s_ff.wdt_cnt != '0) begin
         nxt_s.wdt_cnt = s_ff.wdt_cnt - 24'h00_0001;
      end

      // apb: one wait state, answer from registers
      acc  = apb_req.psel & apb_req.penable;
      done = acc & s_ff.rsp.pready;
      sel  = decode(apb_req.paddr);
      case (sel[1:0])
         2'h0: rd_word = {14'h0, s_ff.ctrl};
         2'h1: rd_word = {17'h0, s_ff.warm, s_ff.cause, lp,
                          s_ff.regs.lvlr_en, s_ff.regs.hvlr_en,
                          s_ff.regs.smps_en, s_ff.chg,
                          s_ff.sync2[IN_SUP], s_ff.sync2[IN_LS],
                          s_ff.sync2[IN_HS]};
         2'h2: rd_word = {s_ff.wdt_cnt, 7'h0, s_ff.wdt_en};
         default: rd_word = {4'h0, s_ff.gio_val, 4'h0, s_ff.gio_dir};
      endcase
      nxt_s.rsp.pready = acc & ~s_ff.rsp.pready;
      if (acc && !s_ff.rsp.pready) begin
         nxt_s.rsp.prdata  = sel[2] ? rd_word : 32'h0000_0000;
         nxt_s.rsp.pslverr = ~sel[2];
      end

      // register writes, ignored while in reset
      if (done && apb_req.pwrite && sel[2] && !s_ff.in_rst) begin
         case (sel[1:0])
            2'h0: nxt_s.ctrl = ctrl_type'(apb_req.pwdata[CTRL_W-1:0]);
            2'h1: nxt_s.cause = s_ff.cause & ~apb_req.pwdata[13:10];
            2'h2: begin
               nxt_s.wdt_en   = apb_req.pwdata[0];
               nxt_s.wdt_load = apb_req.pwdata[31:WDT_LSB];
               nxt_s.wdt_cnt  = apb_req.pwdata[31:WDT_LSB];
            end
            default: begin
               nxt_s.gio_dir = apb_req.pwdata[GIO_N-1:0];
               nxt_s.gio_val = apb_req.pwdata[GVAL_LSB+GIO_N-1:GVAL_LSB];
            end
         endcase
      end

      // warm reset from pin, uart break or watchdog
      trig = pin_trig | uart_break_seen | wdt_exp;
      if (trig) begin
         nxt_s.in_rst   = 1'b1;
         nxt_s.hold_cnt = RST_HOLD_CYC;
         nxt_s.warm     = 1'b1;
         nxt_s.cause    = nxt_s.cause |
                          {wdt_exp, uart_break_seen, 1'b0, pin_trig};
         nxt_s.ctrl     = CTRL_RST;
         nxt_s.ctrl.data_rate = s_ff.ctrl.data_rate;
         nxt_s.ctrl.fw_smps   = s_ff.ctrl.fw_smps;
         nxt_s.ctrl.fw_hvlr   = s_ff.ctrl.fw_hvlr;
         nxt_s.ctrl.fw_lvlr   = s_ff.ctrl.fw_lvlr;
         nxt_s.wdt_en   = 1'b0;
         nxt_s.wdt_cnt  = '0;
         nxt_s.gio_dir  = '0;
         nxt_s.gio_val  = '0;
      end else if (s_ff.in_rst) begin
         if (s_ff.hold_cnt == 5'h0) begin
            nxt_s.in_rst = 1'b0;
         end else begin
            nxt_s.hold_cnt = s_ff.hold_cnt - 5'h1;
         end
      end

      // charger state machine
      case (s_ff.chg)
         CHG_OFF: begin
            nxt_s.chg = s_ff.sync2[IN_BLOW] ? CHG_TRICKLE : CHG_CC;
         end
         CHG_TRICKLE: begin
            if (!s_ff.sync2[IN_BLOW]) begin
               nxt_s.chg = CHG_CC;
            end
         end
         CHG_CC: begin
            if (s_ff.sync2[IN_BLOW]) begin
               nxt_s.chg = CHG_TRICKLE;
            end else if (s_ff.sync2[IN_BFLT]) begin
               nxt_s.chg = CHG_CV;
            end
         end
         CHG_CV: begin
            if (s_ff.sync2[IN_TERM]) begin
               nxt_s.chg = CHG_STANDBY;
            end
         end
         CHG_STANDBY: begin
            if (s_ff.sync2[IN_RECH]) begin
               nxt_s.chg = CHG_CC;
            end
         end
         default: nxt_s.chg = CHG_OFF;
      endcase
      if (!s_ff.sync2[IN_SUP]) begin
         nxt_s.chg = CHG_OFF;
      end
      nxt_s.chg_tr  = nxt_s.chg == CHG_TRICKLE;
      nxt_s.chg_cc  = nxt_s.chg == CHG_CC;
      nxt_s.chg_cv  = nxt_s.chg == CHG_CV;
      nxt_s.chg_cur = nxt_s.ctrl.i_set;

      // regulator enables, gated into low power
      chg_req = s_ff.chg != CHG_OFF;
      lp = s_ff.ctrl.deep_sleep | s_ff.in_rst;
      nxt_s.regs.smps_en = s_ff.sync2[IN_HS] | s_ff.ctrl.fw_smps |
                           chg_req;
      nxt_s.regs.hvlr_en = s_ff.sync2[IN_HS] | s_ff.ctrl.fw_hvlr |
                           chg_req;
      nxt_s.regs.lvlr_en = s_ff.sync2[IN_LS] | s_ff.ctrl.fw_lvlr |
                           chg_req;
      nxt_s.regs.smps_pulse_skip = lp & nxt_s.regs.smps_en;
      nxt_s.regs.hvlr_low_power  = lp & nxt_s.regs.hvlr_en;
      nxt_s.regs.lvlr_low_power  = lp & nxt_s.regs.lvlr_en;
      nxt_s.en_pd = EN_PD_ON;

      // indicator pads, open drain
      if (s_ff.led_cnt == LED_CNT_W'(LED_PERIOD_CYC - 1)) begin
         nxt_s.led_cnt = '0;
      end else begin
         nxt_s.led_cnt = s_ff.led_cnt + LED_CNT_W'(1);
      end
      led_pulse = s_ff.led_cnt < LED_CNT_W'(LED_ON_CYC);
      chg_lit = s_ff.sync2[IN_SUP] & charging(s_ff.chg);
      nxt_s.led0_oe_n = ~(s_ff.ctrl.led0_fw |
         (chg_lit & (s_ff.ctrl.fw_running | led_pulse)));
      nxt_s.led1_oe_n = ~s_ff.ctrl.led1_fw;

      // general pins and pulls, forced safe in reset
      nxt_s.gio_oe_n = nxt_s.in_rst ? '1 : ~nxt_s.gio_dir;
      nxt_s.gio_out  = nxt_s.gio_val;
      nxt_s.pulls.uart_rx_pd        = 1'b1;
      nxt_s.pulls.uart_tx_pu        = 1'b1;
      nxt_s.pulls.spi_pd            = 4'hF;
      nxt_s.pulls.rst_pu            = 1'b1;
      nxt_s.pulls.test_en_strong_pd = 1'b1;
      nxt_s.pulls.gio_pd = nxt_s.in_rst ? '1 : ~nxt_s.gio_dir;
      nxt_s.freerun = ~s_ff.sync2[IN_XTAL];
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff           <= '0;
         s_ff.sync1     <= SYNC_RST;
         s_ff.sync2     <= SYNC_RST;
         s_ff.ctrl      <= CTRL_RST;
         s_ff.cause     <= CAUSE_POR;
         s_ff.en_pd     <= EN_PD_ON;
         s_ff.led0_oe_n <= 1'b1;
         s_ff.led1_oe_n <= 1'b1;
         s_ff.gio_oe_n  <= '1;
         s_ff.pulls     <= '1;
         s_ff.freerun   <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign apb_rsp              = s_ff.rsp;
   assign regs                 = s_ff.regs;
   assign pulls                = s_ff.pulls;
   assign en_pin_pulldown      = s_ff.en_pd;
   assign indicator_pad_0_oe_n = s_ff.led0_oe_n;
   assign indicator_pad_1_oe_n = s_ff.led1_oe_n;
   assign indicator_pad_0_out  = s_ff.led0_oe_n & 1'b0;
   assign indicator_pad_1_out  = s_ff.led1_oe_n & 1'b0;
   assign general_io_pins_oe_n = s_ff.gio_oe_n;
   assign general_io_pins_out  = s_ff.gio_out;
   assign chg_trickle          = s_ff.chg_tr;
   assign chg_cc               = s_ff.chg_cc;
   assign chg_cv               = s_ff.chg_cv;
   assign chg_current          = s_ff.chg_cur;
   assign xtal_sel             = s_ff.ctrl.xtal_sel;
   assign osc_freerun          = s_ff.freerun;
   assign data_rate            = s_ff.ctrl.data_rate;
   assign ram_retained         = s_ff.warm;
   assign chip_reset           = s_ff.in_rst;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_smps_on;
      s_ff.sync2[IN_HS] || s_ff.ctrl.fw_smps || s_ff.chg != CHG_OFF
      |=> s_ff.regs.smps_en;
   endproperty
   a_smps_on: assert property (p_smps_on)
      else $error("switch-mode regulator not enabled");

   property p_lvlr_off;
      !s_ff.sync2[IN_LS] && !s_ff.ctrl.fw_lvlr && s_ff.chg == CHG_OFF
      |=> !s_ff.regs.lvlr_en;
   endproperty
   a_lvlr_off: assert property (p_lvlr_off)
      else $error("low linear regulator on without a request");

   property p_low_power;
      (s_ff.in_rst || s_ff.ctrl.deep_sleep) && s_ff.regs.hvlr_en
      ##1 s_ff.regs.hvlr_en |-> s_ff.regs.hvlr_low_power;
   endproperty
   a_low_power: assert property (p_low_power)
      else $error("regulator not in low power mode");

   property p_chg_off;
      !s_ff.sync2[IN_SUP] |=> s_ff.chg == CHG_OFF && !s_ff.chg_tr;
   endproperty
   a_chg_off: assert property (p_chg_off)
      else $error("charger not off without supply");

   property p_trickle;
      s_ff.chg == CHG_CC && s_ff.sync2[IN_SUP] && s_ff.sync2[IN_BLOW]
      |=> s_ff.chg == CHG_TRICKLE && s_ff.chg_tr;
   endproperty
   a_trickle: assert property (p_trickle)
      else $error("low battery did not enter trickle");

   property p_led_lit;
      s_ff.sync2[IN_SUP] && charging(s_ff.chg) && s_ff.ctrl.fw_running
      |=> !s_ff.led0_oe_n;
   endproperty
   a_led_lit: assert property (p_led_lit)
      else $error("indicator 0 dark while charging");

   property p_no_early_reset;
      !s_ff.in_rst && !pin_trig && !uart_break_seen && !wdt_exp
      |=> !s_ff.in_rst;
   endproperty
   a_no_early_reset: assert property (p_no_early_reset)
      else $error("reset without a source");

   property p_wdt_reset;
      wdt_exp |=> s_ff.in_rst && s_ff.cause[3];
   endproperty
   a_wdt_reset: assert property (p_wdt_reset)
      else $error("watchdog expiry did not reset");

   property p_pins_safe;
      s_ff.in_rst |-> &s_ff.gio_oe_n && &s_ff.pulls;
   endproperty
   a_pins_safe: assert property (p_pins_safe)
      else $error("pins not safe in reset");

   property p_warm_keep;
      trig |=> s_ff.ctrl.data_rate == $past(s_ff.ctrl.data_rate)
      && s_ff.warm && s_ff.ctrl.xtal_sel == 3'h7;
   endproperty
   a_warm_keep: assert property (p_warm_keep)
      else $error("warm reset lost data rate");

   c_fast: cover property (s_ff.chg == CHG_TRICKLE ##1 s_ff.chg == CHG_CC);
   c_standby: cover property (s_ff.chg == CHG_CV ##1 s_ff.chg == CHG_STANDBY);
   c_pin_rst: cover property (pin_trig ##1 s_ff.in_rst);
   c_wdt_rst: cover property (wdt_exp);

endmodule

// >>> test/prc_far_side.sv
// far side model: enable pins, charger supply, battery, slow clock
`timescale 1ns/100ps
module prc_far_side #(
   parameter int LF_HALF = 20 // slow clock half period, cycles
) (
   input  wire logic        pclk,   // clock
   input  wire logic        hs_on,  // hold high pin
   input  wire logic        ls_on,  // hold low pin
   input  wire logic        sup_on, // plug supply
   input  wire logic        full,   // cell full
   input  wire logic [12:0] bat_mv, // cell voltage, mv
   input  wire logic        rst_on, // press reset
   output logic             hs_pin, // high pin
   output logic             ls_pin, // low pin
   output logic             sup,    // supply seen
   output logic             low,    // below trickle
   output logic             flt,    // at float
   output logic             term,   // full
   output logic             drop,   // recharge drop
   output logic             lf_clk, // slow clock
   output logic             rst_n   // reset pin
);
   int lf_cnt;
   // released pins read low through their weak pull-downs
   initial begin
      {hs_pin, ls_pin, sup, low, flt, term, drop, lf_clk} = '0;
      rst_n = 1'b1;
      lf_cnt = 0;
   end
   // pins and comparators move just after the clock edge
   always @(posedge pclk) begin
      hs_pin <= hs_on;
      ls_pin <= ls_on;
      sup <= sup_on;
      low <= bat_mv < 13'h0b54;    // 2900 mv
      flt <= bat_mv >= 13'h1068;   // 4200 mv
      term <= full;
      drop <= bat_mv < 13'h0fd2;   // 150 mv under float
      rst_n <= !rst_on;
      lf_cnt <= (lf_cnt == LF_HALF - 1) ? 0 : lf_cnt + 1;
      if (lf_cnt == LF_HALF - 1)
         lf_clk <= !lf_clk;
   end
endmodule

// >>> test/tb_power_reset_charger_control.sv
// self-checking bench for the power, reset and charger control block
`timescale 1ns/100ps
module tb_power_reset_charger_control
   import prc_pkg::*;
   ;
   localparam int LP = 20;
   localparam int LO = 2;
   localparam int LFH = 20;
   logic pclk = 0, presetn = 0, brk = 0, xtal = 0;
   logic hs_on = 0, ls_on = 0, sup_on = 0, full = 0, rst_on = 0;
   logic [12:0] bat = 13'h0fa0;
   apb_req_type req = '0;
   apb_rsp_type rsp;
   reg_out_type regs;
   pulls_type   pulls;
   logic hs, ls, sup, low, flt, term, drop, lfc, rstn;
   logic p0, p1, po0, po1, trk, ccm, cvm, rr, crst, fr, e;
   logic [1:0]  enpd;
   logic [11:0] goe, gout;
   logic [3:0]  cur, dr_o;
   logic [2:0]  xs_o;
   logic [31:0] q, ctl;
   int err_count = 0, checks = 0, seed = 32'hc2ff;
   logic [12:0] mv [6] = '{13'h09c4, 13'h0e74, 13'h1068, 13'h1068,
                           13'h1004, 13'h0fa0};
   logic [2:0]  st [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h2};
   logic [3:0]  src [3] = '{4'h1, 4'h4, 4'h8};
   logic [7:0]  bad [2] = '{8'h10, 8'h02};

   always #2.5 pclk = !pclk;

   prc_far_side #(.LF_HALF(LFH)) u_prc_far_side (.pclk(pclk),
      .hs_on(hs_on), .ls_on(ls_on), .sup_on(sup_on), .full(full),
      .bat_mv(bat), .rst_on(rst_on), .hs_pin(hs), .ls_pin(ls),
      .sup(sup), .low(low), .flt(flt), .term(term), .drop(drop),
      .lf_clk(lfc), .rst_n(rstn));

   power_reset_charger_control #(.LED_PERIOD_CYC(LP), .LED_ON_CYC(LO))
   u_power_reset_charger_control (.pclk(pclk), .presetn(presetn),
      .apb_req(req), .apb_rsp(rsp), .high_side_reg_enable_pin(hs),
      .low_side_reg_enable_pin(ls), .charger_supply_input(sup),
      .battery_below_trickle(low), .battery_at_float(flt),
      .charge_term_reached(term), .battery_recharge_drop(drop),
      .lf_osc_clk(lfc), .reset_pin_n(rstn), .crystal_present(xtal),
      .uart_break_seen(brk), .regs(regs), .pulls(pulls),
      .en_pin_pulldown(enpd), .indicator_pad_0_oe_n(p0),
      .indicator_pad_1_oe_n(p1), .indicator_pad_0_out(po0),
      .indicator_pad_1_out(po1), .general_io_pins_oe_n(goe),
      .general_io_pins_out(gout), .chg_trickle(trk), .chg_cc(ccm),
      .chg_cv(cvm), .chg_current(cur), .xtal_sel(xs_o),
      .osc_freerun(fr), .data_rate(dr_o), .ram_retained(rr),
      .chip_reset(crst));

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      while (rsp.pready !== 1'b1)
         @(posedge pclk);
      q = rsp.prdata;
      e = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // count cycles with pad 0 sinking over one pulse period
   task automatic leds(input int n);
      int k = 0;
      repeat (LP) begin
         @(posedge pclk);
         k += int'(p0 === 1'b0);
      end
      chk(k, n);
   endtask
   // expected {trickle, cc, cv} for a charger state code
   function automatic logic [2:0] mode(input logic [2:0] s);
      return {s == 3'h1, s == 3'h2, s == 3'h3};
   endfunction
   task automatic give_verdict;
      if (err_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // hang guard
   initial begin
      wt(20000);
      err_count++;
      give_verdict;
   end

   initial begin
      int n;
      wt(12);
      presetn <= 1'b1;
      chk(xs_o, 3'h7);
      chk(fr, 1'b1);
      chk(pulls, 20'hf_ffff);
      chk(enpd, EN_PD_ON);
      chk(goe, 12'hfff);
      apb(0, CTRL_OFS, 0);
      chk(q, 32'h0000_3800);
      apb(0, STATUS_OFS, 0);
      chk(q[13:10], CAUSE_POR);
      hs_on <= 1;
      xtal <= 1;
      wt(6);
      chk(regs, 6'b101000);
      chk(fr, 1'b0);
      apb(0, STATUS_OFS, 0);
      chk(q[0], 1'b1);
      hs_on <= 0;
      ls_on <= 1;
      wt(6);
      chk(regs, 6'b000010);
      ctl = ($random(seed) & 32'h0003_ff80) | 32'h7;
      apb(1, CTRL_OFS, ctl);
      ls_on <= 0;
      wt(6);
      chk(regs, 6'b101010);
      chk(cur, ctl[10:7]);
      apb(1, CTRL_OFS, ctl | 32'h8);
      wt(3);
      chk(regs, 6'h3f);
      foreach (bad[i]) begin
         apb(1, bad[i], 0);
         chk(e, 1'b1);
      end
      apb(0, CTRL_OFS, 0);
      chk(q, ctl | 32'h8);
      apb(1, CTRL_OFS, ctl & 32'hffff_fff0);
      sup_on <= 1;
      foreach (mv[i]) begin
         bat <= mv[i];
         full <= i > 2;
         wt(6);
         chk({trk, ccm, cvm}, mode(st[i]));
         chk(regs, 6'b101010);
         apb(0, STATUS_OFS, 0);
         chk(q[5:2], {st[i], 1'b1});
         leds(st[i] == 3'h4 ? 0 : LO);
      end
      // fast charge falls back to trickle on a sagging cell
      bat <= 13'h09c4;
      wt(6);
      chk({trk, ccm, cvm}, 3'h4);
      apb(1, CTRL_OFS, (ctl & 32'hffff_fff0) | 32'h50);
      wt(3);
      leds(LP);
      chk(p1, 1'b0);
      chk({po0, po1}, 2'b00);
      sup_on <= 0;
      wt(6);
      chk({trk, ccm, cvm}, 3'h0);
      apb(1, CTRL_OFS, ctl);
      apb(1, STATUS_OFS, 32'h0000_3c00);
      for (int s = 0; s < 3; s++) begin
         apb(1, GIO_OFS, 32'h0a5a_0fff);
         wt(2);
         chk(goe, 12'h000);
         chk(gout, 12'ha5a);
         if (s == 2)
            apb(1, WDT_OFS, 32'h0000_0a01);
         rst_on <= s == 0;
         brk <= s == 1;
         @(posedge pclk);
         brk <= 1'b0;
         n = 0;
         while (crst !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
         end
         chk(s != 0 || (n >= 3 * LFH && n <= 8 * LFH), 1'b1);
         wt(2);
         chk(pulls, 20'hf_ffff);
         chk(goe, 12'hfff);
         chk(gout, 12'h000);
         chk(regs, 6'h3f);
         chk(xs_o, 3'h7);
         wt(10 * LFH);
         rst_on <= 0;
         wt(30);
         chk(regs, 6'b101010);
         chk(rr, 1'b1);
         chk(dr_o, ctl[17:14]);
         apb(0, STATUS_OFS, 0);
         chk(q[14:10], {1'b1, src[s]});
         apb(1, STATUS_OFS, 32'h0000_3c00);
      end
      presetn <= 1'b0;
      wt(2);
      chk(rr, 1'b0);
      chk(dr_o, 4'h0);
      give_verdict;
   end
endmodule
